//--- sim/sbsr_ctrl_model.sv
// Purpose: Bus controller model that runs serial polls and byte queries
// Assumes: Bench asks for each poll or query with a one-cycle pulse
// Notes: A poll is always closed one cycle after its capture strobe
`timescale 1ns/1ps
module sbsr_ctrl_model (
  // Clock, reset and bench requests
  input wire logic ref_clk_in,
  input wire logic reset_in,
  input wire logic poll_req_in,
  input wire logic query_req_in,
  // Strobes toward the block
  output logic poll_out,
  output logic poll_done_out,
  output logic query_out
);
  // Closing every poll at once keeps a stale flag from hiding a new one
  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      poll_out <= 1'b0;
      poll_done_out <= 1'b0;
      query_out <= 1'b0;
    end else begin
      poll_out <= poll_req_in;
      poll_done_out <= poll_out;
      query_out <= query_req_in;
    end
  end
endmodule // sbsr_ctrl_model

//--- sim/tb_top.sv
// Purpose: Self-checking bench for the status byte and request logic
// Assumes: Inputs change 1 ns after the rising edge
// Notes: Every round empties all sources, so each request must rise anew
`timescale 1ns/1ps
module tb_top;
  import sbsr_pkg::*;
  logic clk, rst, odp, cal, lst, meas, preq, qreq, sre_wr, oen_wr, ev_rd;
  logic poll, pdone, query, srq;
  logic [7:0] std_ev, std_en, sre_d, pdat, sre_q, qdat, sb_x, q_x;
  logic [15:0] oen_d, ev_q, cond_q, oen_q, ev_x;
  int error_cnt, samples_checked;

  sbsr_top uut (.ref_clk_in(clk), .reset_in(rst),
    .output_data_pending_in(odp), .std_event_in(std_ev),
    .std_event_enable_in(std_en), .cal_busy_in(cal), .list_busy_in(lst),
    .meas_busy_in(meas), .poll_in(poll), .poll_done_in(pdone),
    .poll_data_out(pdat), .service_request_out(srq),
    .sre_write_in(sre_wr), .sre_data_in(sre_d),
    .service_request_enable_out(sre_q), .stb_query_in(query),
    .stb_query_data_out(qdat), .oper_enable_write_in(oen_wr),
    .oper_enable_data_in(oen_d), .oper_event_read_in(ev_rd),
    .oper_event_data_out(ev_q), .oper_cond_out(cond_q),
    .oper_enable_out(oen_q));
  sbsr_ctrl_model ctrl (.ref_clk_in(clk), .reset_in(rst),
    .poll_req_in(preq), .query_req_in(qreq), .poll_out(poll),
    .poll_done_out(pdone), .query_out(query));

  // Compare and count
  task automatic chk(input string nm, input logic [15:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Ask the controller for a poll (p=1) or a query; data valid on return
  task automatic ask(input logic p);
    preq = p;
    qreq = !p;
    cyc(1);
    preq = 0;
    qreq = 0;
    cyc(1);
  endtask
  task automatic summarize;
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // Expected byte without bit 6, from the bench's own view of the sources
  function automatic logic [7:0] sb_exp(input logic [15:0] ev, en);
    sb_exp = {|(ev & en), 1'b0, |(std_ev & std_en), odp, 4'h0};
  endfunction

  // Free-running clock
  initial begin
    clk = 0;
    forever #4 clk = ~clk;
  end
  // Main sequence
  initial begin
    {odp, cal, lst, meas, preq, qreq, sre_wr, oen_wr, ev_rd} = '0;
    {std_ev, std_en, sre_d, oen_d} = '0;
    error_cnt = 0;
    samples_checked = 0;
    rst = 1;
    void'($urandom(6741));
    cyc(20);
    rst = 0;
    cyc(1);
    chk("sre", 16'(sre_q), 16'h0000);
    for (int i = 0; i < 40; i++) begin
      // Empty the sources, set busy (all three in round 0, random after), write both masks, read events
      odp = 0;
      std_ev = 0;
      {meas, lst, cal} = (i == 0) ? 3'b111 : 3'($urandom);
      sre_d = (i == 0) ? 8'hFF : (i == 2) ? 8'h40 : 8'($urandom);
      oen_d = (i == 0) ? 16'hFFFF : 16'($urandom);
      sre_wr = 1;
      oen_wr = 1;
      ev_rd = 1;
      cyc(1);
      sre_wr = 0;
      oen_wr = 0;
      ev_rd = 0;
      cyc(2);
      ev_x = {11'h000, meas, lst, 2'b00, cal};
      chk("sre", 16'(sre_q), 16'(sre_d & SBSR_SRE_KEEP));
      chk("oper_en", oen_q, oen_d);
      chk("cond", cond_q, ev_x);
      chk("event_clr", ev_q, 16'h0000);
      chk("srq_idle", 16'(srq), 16'h0000);
      // Drop busy and load fresh sources
      odp = (i == 1) ? 1'b1 : 1'($urandom);
      std_ev = 8'($urandom);
      std_en = (i == 0) ? 8'hFF : 8'($urandom);
      {meas, lst, cal} = 3'b000;
      cyc(5);
      sb_x = sb_exp(ev_x, oen_d);
      q_x = sb_x | {1'b0, |(sb_x & sre_d), 6'h00};
      chk("event", ev_q, ev_x);
      chk("srq", 16'(srq), 16'(|(sb_x & sre_d)));
      ask(0);
      chk("query", 16'(qdat), 16'(q_x));
      chk("srq_q", 16'(srq), 16'(|(sb_x & sre_d)));
      ask(1);
      chk("poll", 16'(pdat), 16'(q_x));
      cyc(1);
      chk("srq_p", 16'(srq), 16'h0000);
      ask(0);
      chk("query2", 16'(qdat), 16'(q_x));
    end
    summarize();
  end
endmodule // tb_top

//--- src/sbsr_pkg.sv
// Purpose: Constants for the status byte and service request block
// Assumes: One clock, asynchronous active-high reset
// Notes: Bit positions of the status byte and the operation status group
package sbsr_pkg;
  localparam int SBSR_STB_W = 8;
  localparam int SBSR_OPER_W = 16;
  localparam int SBSR_ESR_W = 8;
  localparam int SBSR_BIT_ODP = 4;
  localparam int SBSR_BIT_ESS = 5;
  localparam int SBSR_BIT_RQS = 6;
  localparam int SBSR_BIT_OSS = 7;
  localparam logic [7:0] SBSR_SRE_RESET = 8'h00;
  localparam logic [7:0] SBSR_SRE_KEEP = 8'hBF;
  localparam logic [15:0] SBSR_OPER_USED = 16'h0019;
  localparam logic [15:0] SBSR_OPER_RESET = 16'h0000;
endpackage

//--- src/sbsr_srq_gen.sv
// Purpose: Service request flag generator
// Assumes: Status byte bit 6 is not included in stb
// Notes: Sets when any enabled status bit newly becomes set
`timescale 1ns/1ps
module sbsr_srq_gen
  import sbsr_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic reset_in,
  // Link to status side
  sbsr_srq_if.request_side srq
);
  logic [7:0] masked;
  logic [7:0] masked_d;
  logic rise;
  // Masked byte ignoring bit 6, which cannot be enabled
  assign masked = srq.stb & srq.service_request_enable & SBSR_SRE_KEEP;
  // Per-bit edges, so a second enabled bit still requests while a
  // first one stays set after a poll
  assign rise = |(masked & ~masked_d);
  // Edge memory so a steady bit does not re-request after a poll
  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      masked_d <= 8'h00;
    end else begin
      masked_d <= masked;
    end
  end
  // Set wins over the poll clear so a fresh event is not lost
  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      srq.requested <= 1'b0;
    end else if (rise) begin
      srq.requested <= 1'b1;
    end else if (srq.poll_done) begin
      srq.requested <= 1'b0;
    end
  end
  rise_sets_a: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    rise |=> srq.requested)
    else $error("request flag not set on new masked event");
  poll_clears_a: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    (srq.poll_done && !rise) |=> !srq.requested)
    else $error("poll did not clear request flag");
endmodule // sbsr_srq_gen

//--- src/sbsr_srq_if.sv
// Purpose: Carries status byte summary to the request generator
// Assumes: One clock domain
// Notes: Status side drives byte and mask, request side drives flag
`timescale 1ns/1ps
interface sbsr_srq_if;
  logic [7:0] stb;
  logic [7:0] service_request_enable;
  logic poll_done;
  logic requested;
  modport status_side (output stb, output service_request_enable, output poll_done,
    input requested);
  modport request_side (input stb, input service_request_enable, input poll_done,
    output requested);
endinterface

//--- src/sbsr_top.sv
// Purpose: Status byte, service request and operation status summary
// Assumes: Command parser decodes *SERVICE_REQUEST_ENABLE, *STB?, poll and queries into strobes
// Notes: Standard event group is external, only its bits come in
`timescale 1ns/1ps
module sbsr_top
  import sbsr_pkg::*;
#(
  parameter int OPER_W = SBSR_OPER_W
) (
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic reset_in,
  // Instrument state
  input wire logic output_data_pending_in,
  input wire logic [SBSR_ESR_W-1:0] std_event_in,
  input wire logic [SBSR_ESR_W-1:0] std_event_enable_in,
  input wire logic cal_busy_in,
  input wire logic list_busy_in,
  input wire logic meas_busy_in,
  // Serial poll
  input wire logic poll_in,
  input wire logic poll_done_in,
  output logic [7:0] poll_data_out,
  output logic service_request_out,
  // Service request enable access
  input wire logic sre_write_in,
  input wire logic [7:0] sre_data_in,
  output logic [7:0] service_request_enable_out,
  // Status byte query
  input wire logic stb_query_in,
  output logic [7:0] stb_query_data_out,
  // Operation status group access
  input wire logic oper_enable_write_in,
  input wire logic [OPER_W-1:0] oper_enable_data_in,
  input wire logic oper_event_read_in,
  output logic [OPER_W-1:0] oper_event_data_out,
  output logic [OPER_W-1:0] oper_cond_out,
  output logic [OPER_W-1:0] oper_enable_out
);
  sbsr_srq_if srq ();
  logic [OPER_W-1:0] oper_cond;
  logic [OPER_W-1:0] oper_cond_d;
  logic [OPER_W-1:0] oper_event;
  logic [OPER_W-1:0] oper_enable;
  logic [OPER_W-1:0] oper_fall;
  logic [7:0] service_request_enable;
  logic [7:0] stb;
  logic master_summary;
  logic ess;
  logic oss;

  // Condition register, unused bits held at zero
  always_comb begin
    oper_cond = '0;
    oper_cond[0] = cal_busy_in;
    oper_cond[3] = list_busy_in;
    oper_cond[4] = meas_busy_in;
  end

  // Previous condition for the negative transition filter
  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      oper_cond_d <= '0;
    end else begin
      oper_cond_d <= oper_cond;
    end
  end
  assign oper_fall = oper_cond_d & ~oper_cond;

  // Event register; a completion arriving with the read survives it
  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      oper_event <= '0;
    end else if (oper_event_read_in) begin
      oper_event <= oper_fall;
    end else begin
      oper_event <= oper_event | oper_fall;
    end
  end

  // Operation event enable, full width, unused positions meaningless
  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      oper_enable <= '0;
    end else if (oper_enable_write_in) begin
      oper_enable <= oper_enable_data_in;
    end
  end

  // Service request enable; position 6 always stored as zero
  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      service_request_enable <= SBSR_SRE_RESET;
    end else if (sre_write_in) begin
      service_request_enable <= sre_data_in & SBSR_SRE_KEEP;
    end
  end

  // Summaries follow their sources, no poll term at all
  assign ess = |(std_event_in & std_event_enable_in);
  assign oss = |(oper_event & oper_enable);

  // Status byte without bit 6; low nibble is hard zero
  always_comb begin
    stb = 8'h00;
    stb[SBSR_BIT_ODP] = output_data_pending_in;
    stb[SBSR_BIT_ESS] = ess;
    stb[SBSR_BIT_OSS] = oss;
  end

  // Master summary is live, so a query cannot disturb it
  assign master_summary = |(stb & service_request_enable);

  assign srq.stb = stb;
  assign srq.service_request_enable = service_request_enable;
  assign srq.poll_done = poll_done_in;

  sbsr_srq_gen u_srq_gen (
    .ref_clk_in(ref_clk_in),
    .reset_in(reset_in),
    .srq(srq)
  );

  // Poll byte, registered; bit 6 from the request flag
  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      poll_data_out <= 8'h00;
    end else if (poll_in) begin
      poll_data_out <= stb | {1'b0, srq.requested, 6'h00};
    end
  end

  // Query byte, registered; bit 6 from master summary
  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      stb_query_data_out <= 8'h00;
    end else if (stb_query_in) begin
      stb_query_data_out <= stb | {1'b0, master_summary, 6'h00};
    end
  end

  assign service_request_out = srq.requested;
  assign service_request_enable_out = service_request_enable;
  assign oper_event_data_out = oper_event;
  assign oper_cond_out = oper_cond;
  assign oper_enable_out = oper_enable;

  low_nibble_a: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    poll_in |=> poll_data_out[3:0] == 4'h0)
    else $error("poll byte low nibble not zero");
  poll_bit6_a: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    poll_in |=> poll_data_out[6] == $past(srq.requested))
    else $error("poll bit 6 not request flag");
  query_bit6_a: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    stb_query_in |=> stb_query_data_out[6] == $past(master_summary))
    else $error("query bit 6 not master summary");
  poll_odp_a: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    poll_in |=> poll_data_out[4] == $past(output_data_pending_in))
    else $error("poll bit 4 wrong");
  sre_bit6_a: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    sre_write_in |=> service_request_enable == ($past(sre_data_in) & 8'hBF))
    else $error("enable mask write wrong");
  fall_event_a: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    (oper_cond_d[4] && !oper_cond[4]) |=> oper_event[4])
    else $error("falling condition not latched");
  read_clears_a: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    (oper_event_read_in && oper_fall == '0) |=> !oss)
    else $error("event read did not clear summary");
  mss_zero_a: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    ((output_data_pending_in && service_request_enable[SBSR_BIT_ODP])
      || ((|(std_event_in & std_event_enable_in)) && service_request_enable[SBSR_BIT_ESS])
      || ((|(oper_event & oper_enable)) && service_request_enable[SBSR_BIT_OSS]))
      |-> master_summary)
    else $error("master summary low with enabled source set");
endmodule // sbsr_top
